// >>> csip_pkg.sv
// package: constants and register map of the stack and indirect pointer block
// assumes: shared by csip_stack, csip_ptr and csip_top on one clock
package csip_pkg;
   // return stack geometry
   localparam int STK_WIDTH = 15;
   localparam int STK_DEPTH = 16;
   // pointer geometry and targets
   localparam int PTR_W       = 16;
   localparam int PTR_PM_BIT  = 15;
   localparam int DM_AW       = 12;
   localparam int BANK_BYTES  = 128;
   localparam int GPR_BYTES   = 80;
   localparam int GPR_START   = 32;
   localparam logic [15:0] LIN_BASE  = 16'h2000;
   localparam logic [15:0] LIN_LIMIT = 16'h29B0;
   localparam logic [15:0] DIR_LIMIT = 16'h1000;
   localparam int IND_DW      = 8;
   localparam int PM_DW       = 14;
   localparam int NUM_INSTR   = 49;
   // core context saved around interrupts: w, z/dc/c, bank, pc latch
   localparam int CTX_W       = 23;
   // apb register byte offsets
   localparam logic [7:0] REG_CTRL  = 8'h00;
   localparam logic [7:0] REG_CAUSE = 8'h04;
   localparam logic [7:0] REG_ISTAT = 8'h08;
   localparam logic [7:0] REG_IMASK = 8'h0C;
   localparam logic [7:0] REG_PTR0  = 8'h10;
   localparam logic [7:0] REG_PTR1  = 8'h14;
   localparam logic [7:0] REG_STKST = 8'h18;
   // field positions
   localparam int CTRL_FRST = 0;
   localparam int CAUSE_OVF = 0;
   localparam int CAUSE_UNF = 1;
   localparam int EV_OVF    = 0;
   localparam int EV_UNF    = 1;
   localparam int EV_ENTRY  = 2;
   localparam int EV_PMWR   = 3;
   localparam int NUM_EV    = 4;
   // reset values
   localparam logic       CTRL_RST  = 1'b0;
   localparam logic [3:0] IMASK_RST = 4'h0;
   // indirect access sequencer, gray along idle-acc-xtra-done
   typedef enum logic [1:0] {
      CSIP_IDLE = 2'b00,
      CSIP_ACC  = 2'b01,
      CSIP_XTRA = 2'b11,
      CSIP_DONE = 2'b10
   } csip_state_t;
endpackage : csip_pkg

// >>> csip_stack.sv
// return address stack with occupancy count and fault pulses
// assumes: push/pop are one-cycle strobes from the core on i_sys_clk
`timescale 1ns/100ps
`default_nettype none
module csip_stack #(
   parameter int WIDTH = csip_pkg::STK_WIDTH,
   parameter int DEPTH = csip_pkg::STK_DEPTH
) (
   // clock and reset
   input  wire logic                     i_sys_clk,
   input  wire logic                     i_sys_rst,
   input  wire logic                     i_clk_en,
   // stack operations
   input  wire logic                     i_push,
   input  wire logic                     i_pop,
   input  wire logic                     i_clear,
   input  wire logic [WIDTH-1:0]         i_data,
   // state
   output logic      [WIDTH-1:0]         o_top,
   output logic      [$clog2(DEPTH):0]   o_depth,
   output logic                          o_ovf,
   output logic                          o_unf
);
   import csip_pkg::*;
   localparam int CW = $clog2(DEPTH) + 1;
   localparam logic [CW-1:0] FULL = CW'(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [CW-1:0]               cnt;
      logic                        ovf;
      logic                        unf;
   } csip_stk_t;

   csip_stk_t s_q, s_d;

   // push beats pop when both arrive; a faulting op leaves the stack untouched
   always_comb begin
      s_d     = s_q;
      s_d.ovf = 1'b0;
      s_d.unf = 1'b0;
      if (i_clear) begin
         s_d.cnt = '0;
      end else if (i_push) begin
         if (s_q.cnt == FULL) begin
            s_d.ovf = 1'b1;
         end else begin
            s_d.mem[s_q.cnt[CW-2:0]] = i_data;
            s_d.cnt = s_q.cnt + 1'b1;
         end
      end else if (i_pop) begin
         if (s_q.cnt == '0) begin
            s_d.unf = 1'b1;
         end else begin
            s_d.cnt = s_q.cnt - 1'b1;
         end
      end
   end

   always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         s_q <= '0;
      end else if (i_clk_en) begin
         s_q <= s_d;
      end
   end

   // empty stack shows entry zero; caller must not rely on it
   assign o_top   = (s_q.cnt == '0) ? s_q.mem[0] : s_q.mem[s_q.cnt[CW-2:0] - 1'b1];
   assign o_depth = s_q.cnt;
   assign o_ovf   = s_q.ovf;
   assign o_unf   = s_q.unf;
endmodule : csip_stack
`default_nettype wire

// >>> csip_ptr.sv
// one indirect pointer register with its target decode
// assumes: load sources are already prioritised by the caller
`timescale 1ns/100ps
`default_nettype none
module csip_ptr (
   // clock and reset
   input  wire logic                       i_sys_clk,
   input  wire logic                       i_sys_rst,
   input  wire logic                       i_clk_en,
   // update
   input  wire logic                       i_load,
   input  wire logic [csip_pkg::PTR_W-1:0] i_val,
   input  wire logic                       i_add,
   input  wire logic [csip_pkg::PTR_W-1:0] i_off,
   // value and decode
   output logic      [csip_pkg::PTR_W-1:0] o_val,
   output logic                            o_is_pm,
   output logic                            o_unimpl,
   output logic      [csip_pkg::DM_AW-1:0] o_dm_addr,
   output logic      [14:0]                o_pm_addr
);
   import csip_pkg::*;

   typedef struct packed {
      logic [PTR_W-1:0] val;
   } csip_ptr_t;

   csip_ptr_t p_q, p_d;
   logic [PTR_W-1:0] lin_off;
   logic [PTR_W-1:0] lin_bank;
   logic [PTR_W-1:0] lin_idx;

   // full 16-bit register, arithmetic wraps
   always_comb begin
      p_d = p_q;
      if (i_load) begin
         p_d.val = i_val;
      end else if (i_add) begin
         p_d.val = p_q.val + i_off;
      end
   end

   always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         p_q <= '0;
      end else if (i_clk_en) begin
         p_q <= p_d;
      end
   end

   // linear window packs the 80-byte gpr slices of each bank end to end
   always_comb begin
      lin_off   = p_q.val - LIN_BASE;
      lin_bank  = lin_off / PTR_W'(GPR_BYTES);
      lin_idx   = lin_off % PTR_W'(GPR_BYTES);
      o_is_pm   = p_q.val[PTR_PM_BIT];
      o_pm_addr = p_q.val[14:0];
      o_unimpl  = 1'b0;
      o_dm_addr = p_q.val[DM_AW-1:0];
      if (!o_is_pm && p_q.val >= DIR_LIMIT) begin
         if (p_q.val >= LIN_BASE && p_q.val < LIN_LIMIT) begin
            o_dm_addr = {lin_bank[4:0], 7'(lin_idx + PTR_W'(GPR_START))};
         end else begin
            o_unimpl = 1'b1;
         end
      end
   end
   assign o_val = p_q.val;
endmodule : csip_ptr
`default_nettype wire

// >>> csip_top.sv
// core support: return stack, interrupt context shadows, two indirect pointers
// assumes: core, data memory and program memory share i_sys_clk; apb master
// What this block does
// - a return stack holds sixteen fifteen-bit return addresses.
// - stack overflow and underflow each set their own flag in the reset cause register.
// - with the fault reset option on, a stack fault also requests a device reset.
// - interrupt entry copies core registers into shadows and return restores them.
// - two independent sixteen-bit indirect pointers exist.
// - each pointer reaches every file register and program memory.
// - an indirect access to program memory takes one extra cycle.
// - general purpose memory is also reachable through a linear address window.
// - pointer load and offset operations of the core instruction set are served.
// - pointer bit 15 steers the indirect access to program memory.
// - an indirect program memory read returns the low eight bits of the word.
// - indirect writes aimed at program memory are dropped.
//
// Implementation choices: the address map and the APB slave port.
`timescale 1ns/100ps
`default_nettype none
module csip_top (
   // clock, reset, enable
   input  wire logic                        i_sys_clk,
   input  wire logic                        i_sys_rst,
   input  wire logic                        i_clk_en,
   // apb slave
   input  wire logic                        i_psel,
   input  wire logic                        i_penable,
   input  wire logic                        i_pwrite,
   input  wire logic [7:0]                  i_paddr,
   input  wire logic [31:0]                 i_pwdata,
   output logic      [31:0]                 o_prdata,
   output logic                             o_pready,
   output logic                             o_pslverr,
   output logic                             o_irq,
   // return stack from the core
   input  wire logic                        i_push,
   input  wire logic                        i_pop,
   input  wire logic [csip_pkg::STK_WIDTH-1:0] i_ret_addr,
   output logic      [csip_pkg::STK_WIDTH-1:0] o_ret_addr,
   output logic                             o_soft_reset,
   // interrupt context
   input  wire logic                        i_int_entry,
   input  wire logic                        i_int_return,
   input  wire logic [csip_pkg::CTX_W-1:0]  i_ctx,
   output logic                             o_ctx_valid,
   output logic      [csip_pkg::CTX_W-1:0]  o_ctx,
   // pointer operations from the decoder
   input  wire logic                        i_ptr_sel,
   input  wire logic                        i_ptr_load,
   input  wire logic                        i_ptr_add,
   input  wire logic [csip_pkg::PTR_W-1:0]  i_ptr_val,
   output logic      [csip_pkg::PTR_W-1:0]  o_ptr0,
   output logic      [csip_pkg::PTR_W-1:0]  o_ptr1,
   // indirect data port request
   input  wire logic                        i_ind_req,
   input  wire logic                        i_ind_sel,
   input  wire logic                        i_ind_we,
   input  wire logic [csip_pkg::IND_DW-1:0] i_ind_wdata,
   output logic                             o_ind_busy,
   output logic                             o_ind_ack,
   output logic      [csip_pkg::IND_DW-1:0] o_ind_rdata,
   // data memory port, read data valid while strobe is high
   output logic      [csip_pkg::DM_AW-1:0]  o_dm_addr,
   output logic                             o_dm_re,
   output logic                             o_dm_we,
   output logic      [csip_pkg::IND_DW-1:0] o_dm_wdata,
   input  wire logic [csip_pkg::IND_DW-1:0] i_dm_rdata,
   // program memory read port
   output logic      [14:0]                 o_pm_addr,
   output logic                             o_pm_re,
   input  wire logic [csip_pkg::PM_DW-1:0]  i_pm_rdata
);
   import csip_pkg::*;

   typedef struct packed {
      logic                ctrl_frst;
      logic                cause_ovf;
      logic                cause_unf;
      logic [NUM_EV-1:0]   istat;
      logic [NUM_EV-1:0]   imask;
      logic [31:0]         prdata;
      logic                perr;
      logic [CTX_W-1:0]    sh_ctx;
      logic [PTR_W-1:0]    sh_p0;
      logic [PTR_W-1:0]    sh_p1;
      logic                ctx_vld;
      logic [CTX_W-1:0]    ctx;
      csip_state_t         st;
      logic                a_we;
      logic                a_pm;
      logic                a_unimpl;
      logic [IND_DW-1:0]   a_wdata;
      logic [DM_AW-1:0]    a_dm;
      logic [14:0]         a_pm_addr;
      logic [IND_DW-1:0]   rdata;
      logic                srst;
   } csip_top_t;

   csip_top_t r_q, r_d;

   // submodule wires
   logic [PTR_W-1:0]          p_val [2];
   logic                      p_pm [2];
   logic                      p_un [2];
   logic [DM_AW-1:0]          p_dm [2];
   logic [14:0]               p_pma [2];
   logic [1:0]                p_load;
   logic [1:0]                p_add;
   logic [PTR_W-1:0]          p_new [2];
   logic [$clog2(STK_DEPTH):0] stk_depth;
   logic                      stk_ovf;
   logic                      stk_unf;
   logic                      fault;
   logic                      apb_setup;
   logic                      apb_wr;
   logic                      apb_rd;
   logic [NUM_EV-1:0]         ev;

   assign apb_setup = i_psel && !i_penable;
   assign apb_wr    = i_psel && i_penable && i_pwrite;
   assign apb_rd    = i_psel && i_penable && !i_pwrite;
   assign fault     = stk_ovf || stk_unf;

   csip_stack #(
      .WIDTH (STK_WIDTH),
      .DEPTH (STK_DEPTH)
   ) u_stack (
      .i_sys_clk (i_sys_clk),
      .i_sys_rst (i_sys_rst),
      .i_clk_en  (i_clk_en),
      .i_push    (i_push),
      .i_pop     (i_pop),
      .i_clear   (r_q.srst),
      .i_data    (i_ret_addr),
      .o_top     (o_ret_addr),
      .o_depth   (stk_depth),
      .o_ovf     (stk_ovf),
      .o_unf     (stk_unf)
   );

   // pointer load priority: context restore, then core, then software
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         p_load[i] = 1'b0;
         p_add[i]  = 1'b0;
         p_new[i]  = i_ptr_val;
         if (i_int_return) begin
            p_load[i] = 1'b1;
            p_new[i]  = (i == 0) ? r_q.sh_p0 : r_q.sh_p1;
         end else if (i_ptr_sel == 1'(i) && (i_ptr_load || i_ptr_add)) begin
            p_load[i] = i_ptr_load;
            p_add[i]  = !i_ptr_load;
         end else if (apb_wr && i_paddr == (i == 0 ? REG_PTR0 : REG_PTR1)) begin
            p_load[i] = 1'b1;
            p_new[i]  = i_pwdata[PTR_W-1:0];
         end
      end
   end

   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_ptr
         csip_ptr u_ptr (
            .i_sys_clk (i_sys_clk),
            .i_sys_rst (i_sys_rst),
            .i_clk_en  (i_clk_en),
            .i_load    (p_load[g]),
            .i_val     (p_new[g]),
            .i_add     (p_add[g]),
            .i_off     (i_ptr_val),
            .o_val     (p_val[g]),
            .o_is_pm   (p_pm[g]),
            .o_unimpl  (p_un[g]),
            .o_dm_addr (p_dm[g]),
            .o_pm_addr (p_pma[g])
         );
      end
   endgenerate

   // event sources feeding the sticky status bits
   always_comb begin
      ev           = '0;
      ev[EV_OVF]   = stk_ovf;
      ev[EV_UNF]   = stk_unf;
      ev[EV_ENTRY] = i_int_entry;
      ev[EV_PMWR]  = (r_q.st == CSIP_ACC) && r_q.a_pm && r_q.a_we;
   end

   // main next-state logic
   always_comb begin
      r_d         = r_q;
      r_d.ctx_vld = 1'b0;
      r_d.srst    = 1'b0;

      // stack faults: flag always, reset only when enabled
      if (fault && r_q.ctrl_frst) begin
         r_d.srst = 1'b1;
      end

      // shadows copy on entry, hand back on return
      if (i_int_entry) begin
         r_d.sh_ctx = i_ctx;
         r_d.sh_p0  = p_val[0];
         r_d.sh_p1  = p_val[1];
      end else if (i_int_return) begin
         r_d.ctx     = r_q.sh_ctx;
         r_d.ctx_vld = 1'b1;
      end

      // indirect access sequencer
      case (r_q.st)
         CSIP_IDLE: begin
            if (i_ind_req) begin
               r_d.st        = CSIP_ACC;
               r_d.a_we      = i_ind_we;
               r_d.a_wdata   = i_ind_wdata;
               r_d.a_pm      = p_pm[i_ind_sel];
               r_d.a_unimpl  = p_un[i_ind_sel];
               r_d.a_dm      = p_dm[i_ind_sel];
               r_d.a_pm_addr = p_pma[i_ind_sel];
            end
         end
         CSIP_ACC: begin
            if (r_q.a_pm) begin
               r_d.st = CSIP_XTRA;
            end else begin
               r_d.st    = CSIP_DONE;
               r_d.rdata = r_q.a_unimpl ? '0 : i_dm_rdata;  // unmapped reads as zero
            end
         end
         CSIP_XTRA: begin
            r_d.st    = CSIP_DONE;
            r_d.rdata = i_pm_rdata[IND_DW-1:0];
         end
         CSIP_DONE: begin
            r_d.st = CSIP_IDLE;
         end
         default: begin
            r_d.st = CSIP_IDLE;
         end
      endcase

      // apb: read data captured in setup, answered in the access phase
      if (apb_setup) begin
         r_d.prdata = '0;
         r_d.perr   = 1'b0;
         case (i_paddr)
            REG_CTRL:  r_d.prdata[CTRL_FRST] = r_q.ctrl_frst;
            REG_CAUSE: begin
               r_d.prdata[CAUSE_OVF] = r_q.cause_ovf;
               r_d.prdata[CAUSE_UNF] = r_q.cause_unf;
            end
            REG_ISTAT: r_d.prdata[NUM_EV-1:0] = r_q.istat;
            REG_IMASK: r_d.prdata[NUM_EV-1:0] = r_q.imask;
            REG_PTR0:  r_d.prdata[PTR_W-1:0]  = p_val[0];
            REG_PTR1:  r_d.prdata[PTR_W-1:0]  = p_val[1];
            REG_STKST: r_d.prdata[$bits(stk_depth)-1:0] = stk_depth;
            default:   r_d.perr = 1'b1;
         endcase
      end
      if (apb_wr) begin
         case (i_paddr)
            REG_CTRL:  r_d.ctrl_frst = i_pwdata[CTRL_FRST];
            REG_CAUSE: begin
               // write one clears
               if (i_pwdata[CAUSE_OVF]) r_d.cause_ovf = 1'b0;
               if (i_pwdata[CAUSE_UNF]) r_d.cause_unf = 1'b0;
            end
            REG_IMASK: r_d.imask = i_pwdata[NUM_EV-1:0];
            default: ;
         endcase
      end
      if (apb_rd && i_paddr == REG_ISTAT) begin
         r_d.istat = r_q.istat & ~r_q.prdata[NUM_EV-1:0]; // clears what it returned
      end

      // hardware sets come last so a simultaneous clear never loses an event
      if (stk_ovf) r_d.cause_ovf = 1'b1;
      if (stk_unf) r_d.cause_unf = 1'b1;
      r_d.istat = r_d.istat | ev;
   end

   // cause flags survive the stack-fault reset; only the stack is cleared
   always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         r_q           <= '0;
         r_q.st        <= CSIP_IDLE;
         r_q.ctrl_frst <= CTRL_RST;
         r_q.imask     <= IMASK_RST;
      end else if (i_clk_en) begin
         r_q <= r_d;
      end
   end

   // outputs
   assign o_prdata     = r_q.prdata;
   assign o_pready     = 1'b1;                              // no wait states
   assign o_pslverr    = i_psel && i_penable && r_q.perr;
   assign o_irq        = |(r_q.istat & r_q.imask);
   assign o_soft_reset = r_q.srst;
   assign o_ctx_valid  = r_q.ctx_vld;
   assign o_ctx        = r_q.ctx;
   assign o_ptr0       = p_val[0];
   assign o_ptr1       = p_val[1];
   assign o_ind_busy   = (r_q.st != CSIP_IDLE) && (r_q.st != CSIP_DONE);
   assign o_ind_ack    = (r_q.st == CSIP_DONE);
   assign o_ind_rdata  = r_q.rdata;
   assign o_dm_addr    = r_q.a_dm;
   assign o_dm_wdata   = r_q.a_wdata;
   assign o_dm_re      = (r_q.st == CSIP_ACC) && !r_q.a_pm && !r_q.a_we && !r_q.a_unimpl;
   // program memory is never written through a pointer
   assign o_dm_we      = (r_q.st == CSIP_ACC) && !r_q.a_pm && r_q.a_we
                         && !r_q.a_unimpl;
   assign o_pm_addr    = r_q.a_pm_addr;
   assign o_pm_re      = (r_q.st == CSIP_XTRA) && !r_q.a_we;
endmodule : csip_top
`default_nettype wire

// >>> csip_props.sv
// checker: port timing of the stack, context and indirect port
// assumes: bound into csip_top, one clock
`timescale 1ns/100ps
`default_nettype none
module csip_props (
   // clock and reset
   input wire logic        i_sys_clk,
   input wire logic        i_sys_rst,
   // core strobes
   input wire logic        i_push,
   input wire logic        i_pop,
   input wire logic        o_soft_reset,
   input wire logic        i_int_return,
   input wire logic        o_ctx_valid,
   // indirect port
   input wire logic        i_ind_req,
   input wire logic        i_ind_sel,
   input wire logic        i_ind_we,
   input wire logic [15:0] o_ptr0,
   input wire logic [15:0] o_ptr1,
   input wire logic        o_ind_busy,
   input wire logic        o_ind_ack,
   input wire logic        o_pm_re,
   input wire logic        o_dm_we
);
   import csip_pkg::*;
   logic take;
   logic pm;
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_sys_rst);
   // a request is taken only while idle
   assign take = i_ind_req && !o_ind_busy && !o_ind_ack;
   assign pm   = i_ind_sel ? o_ptr1[PTR_PM_BIT] : o_ptr0[PTR_PM_BIT];
   a_pm_rd_extra: assert property (
      take && pm && !i_ind_we |=> o_ind_busy && !o_pm_re ##1 o_pm_re ##1 o_ind_ack)
      else $error("pm read length");
   a_pm_wr_drop: assert property (
      take && pm && i_ind_we |=> (!o_dm_we && !o_ind_ack) [*2] ##1 o_ind_ack)
      else $error("pm write not dropped");
   a_dm_path: assert property (
      take && !pm |=> o_ind_busy && !o_pm_re ##1 o_ind_ack)
      else $error("dm access length");
   a_ack_single: assert property (
      o_ind_ack |=> !o_ind_ack && !o_ind_busy)
      else $error("ack too long");
   a_fault_cause: assert property (
      o_soft_reset |-> $past(i_push || i_pop, 2))
      else $error("stray soft reset");
   a_reset_pulse: assert property (
      o_soft_reset |=> !o_soft_reset)
      else $error("reset too long");
   a_ctx_restore: assert property (
      i_int_return |=> o_ctx_valid)
      else $error("no context restore");
   a_ctx_cause: assert property (
      o_ctx_valid |-> $past(i_int_return))
      else $error("stray context restore");
   // main scenarios reached
   c_pm_read: cover property (take && pm && !i_ind_we);
   c_pm_write: cover property (take && pm && i_ind_we);
   c_soft_reset: cover property (o_soft_reset);
endmodule : csip_props
bind csip_top csip_props csip_props_inst (.*);
`default_nettype wire

// >>> csip_top_tb.sv
// testbench: register, stack, context and indirect port sequences
// assumes: csip_top alone; memories answer with address-derived data
`timescale 1ns/100ps
`default_nettype none
module csip_top_tb;
   import csip_pkg::*;
   logic i_sys_clk = 1'b0, i_sys_rst, i_clk_en, i_psel, i_penable;
   logic i_pwrite, i_push, i_pop, i_int_entry, i_int_return, lerr;
   logic i_ptr_sel, i_ptr_load, i_ptr_add, i_ind_req, i_ind_sel, i_ind_we;
   logic o_pready, o_pslverr, o_irq, o_soft_reset, o_ctx_valid;
   logic o_ind_busy, o_ind_ack, o_dm_re, o_dm_we, o_pm_re;
   logic [7:0] i_paddr, i_ind_wdata, i_dm_rdata, o_ind_rdata, o_dm_wdata, ex;
   logic [31:0] i_pwdata, o_prdata;
   logic [14:0] i_ret_addr, o_ret_addr, o_pm_addr, last_a;
   logic [22:0] i_ctx, o_ctx;
   logic [15:0] i_ptr_val, o_ptr0, o_ptr1;
   logic [11:0] o_dm_addr;
   logic [13:0] i_pm_rdata;
   logic [15:0] tp [6] = '{16'h0123, 16'h2055, 16'h29AF, 16'h29B0, 16'h1000, 16'h9234};
   logic [14:0] ta [6] = '{15'h0123, 15'h00A5, 15'h0F6F, 15'h0, 15'h0, 15'h1234};
   int fails = 0, num_checks = 0, nwr = 0, nrst = 0;
   // high program bits set so a full-word return would show
   assign i_dm_rdata = o_dm_addr[7:0] ^ 8'h5A;
   assign i_pm_rdata = {6'h2A, o_pm_addr[7:0] ^ 8'hC3};
   always #10 i_sys_clk = ~i_sys_clk;
   csip_top csip_top_inst (.i_sys_clk, .i_sys_rst, .i_clk_en, .i_psel,
      .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pready,
      .o_pslverr, .o_irq, .i_push, .i_pop, .i_ret_addr, .o_ret_addr,
      .o_soft_reset, .i_int_entry, .i_int_return, .i_ctx, .o_ctx_valid,
      .o_ctx, .i_ptr_sel, .i_ptr_load, .i_ptr_add, .i_ptr_val, .o_ptr0,
      .o_ptr1, .i_ind_req, .i_ind_sel, .i_ind_we, .i_ind_wdata, .o_ind_busy,
      .o_ind_ack, .o_ind_rdata, .o_dm_addr, .o_dm_re, .o_dm_we, .o_dm_wdata,
      .i_dm_rdata, .o_pm_addr, .o_pm_re, .i_pm_rdata);
   // monitor: last address, data writes, soft resets
   always @(posedge i_sys_clk) begin
      if (o_dm_re || o_dm_we || o_pm_re) last_a <= o_pm_re ? o_pm_addr : {3'h0, o_dm_addr};
      nwr <= nwr + int'(o_dm_we);
      nrst <= nrst + int'(o_soft_reset);
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // apb cycle; waits for pready
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
         output logic [31:0] r);
      @(posedge i_sys_clk);
      i_psel <= 1'b1;
      i_pwrite <= w;
      i_paddr <= a;
      i_pwdata <= d;
      @(posedge i_sys_clk);
      i_penable <= 1'b1;
      do @(posedge i_sys_clk); while (o_pready !== 1'b1);
      r = o_prdata;
      lerr = o_pslverr;
      i_psel <= 1'b0;
      i_penable <= 1'b0;
   endtask : apb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      apb(1'b1, a, d, r);
   endtask : wr
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] r;
      apb(1'b0, a, 32'h0, r);
      chk(r, e);
   endtask : rdc
   // one stack strobe; idle edge after so flags have landed
   task automatic stk(input logic pu, input logic po, input logic [14:0] a);
      @(posedge i_sys_clk);
      i_push <= pu;
      i_pop <= po;
      i_ret_addr <= a;
      @(posedge i_sys_clk);
      i_push <= 1'b0;
      i_pop <= 1'b0;
      @(posedge i_sys_clk);
   endtask : stk
   task automatic fill;
      for (int i = 0; i < 17; i++) stk(1'b1, 1'b0, 15'h7F00 - i[14:0]);
      repeat (3) @(posedge i_sys_clk);
   endtask : fill
   task automatic evt(input logic r);
      @(posedge i_sys_clk);
      i_int_entry <= !r;
      i_int_return <= r;
      @(posedge i_sys_clk);
      i_int_entry <= 1'b0;
      i_int_return <= 1'b0;
      #1;
   endtask : evt
   // indirect request; cycles from acceptance to ack
   task automatic ind(input logic s, input logic we, input int ne,
         input logic [7:0] re);
      int n;
      @(posedge i_sys_clk);
      i_ind_req <= 1'b1;
      i_ind_sel <= s;
      i_ind_we <= we;
      @(posedge i_sys_clk);
      i_ind_req <= 1'b0;
      n = 0;
      do begin
         @(posedge i_sys_clk);
         #1 n++;
      end while (o_ind_ack !== 1'b1 && n < 8);
      chk(n, ne);
      if (!we) chk(o_ind_rdata, re);
   endtask : ind
   task automatic end_sim;
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : end_sim
   // run is a few hundred cycles
   initial begin
      #40_000;
      fails++;
      end_sim();
   end
   initial begin
      {i_psel, i_penable, i_pwrite, i_push, i_pop, i_int_entry, i_int_return, i_ptr_sel} = '0;
      {i_ptr_load, i_ptr_add, i_ind_req, i_ind_sel, i_ind_we, i_paddr, i_ind_wdata} = '0;
      {i_pwdata, i_ret_addr, i_ctx, i_ptr_val} = '0;
      i_clk_en = 1'b1;
      i_sys_rst = 1'b1;
      repeat (4) @(posedge i_sys_clk);
      i_sys_rst <= 1'b0;
      // registers clear, unmapped refused
      for (int a = 0; a <= 8'h18; a += 4) rdc(a[7:0], 32'h0);
      rdc(8'h1C, 32'h0);
      chk(lerr, 1'b1);
      $display("test reset finished");
      // pointers apart, core load, wrapping add
      wr(REG_PTR0, 32'h0000_A5C3);
      wr(REG_PTR1, 32'h0000_5A3C);
      rdc(REG_PTR0, 32'h0000_A5C3);
      rdc(REG_PTR1, 32'h0000_5A3C);
      @(posedge i_sys_clk);
      i_ptr_sel <= 1'b1;
      i_ptr_load <= 1'b1;
      i_ptr_val <= 16'hFFFF;
      @(posedge i_sys_clk);
      i_ptr_load <= 1'b0;
      i_ptr_add <= 1'b1;
      i_ptr_val <= 16'h0002;
      @(posedge i_sys_clk);
      i_ptr_add <= 1'b0;
      #1 chk(o_ptr1, 16'h0001);
      chk(o_ptr0, 16'hA5C3);
      $display("test pointers finished");
      // push past full, unmask the event, unwind, pop once too many
      fill();
      rdc(REG_STKST, 32'h0000_0010);
      rdc(REG_CAUSE, 32'h0000_0001);
      chk(o_irq, 1'b0);
      wr(REG_IMASK, 32'h0000_0001);
      #1 chk(o_irq, 1'b1);
      rdc(REG_ISTAT, 32'h0000_0001);
      #1 chk(o_irq, 1'b0);
      wr(REG_CAUSE, 32'h0000_0001);
      rdc(REG_CAUSE, 32'h0);
      for (int i = 15; i >= 0; i--) begin
         chk(o_ret_addr, 15'h7F00 - i[14:0]);
         stk(1'b0, 1'b1, 15'h0);
      end
      stk(1'b0, 1'b1, 15'h0);
      rdc(REG_CAUSE, 32'h0000_0002);
      chk(nrst, 0);
      $display("test stack finished");
      // fault reset on: overflow also empties the stack
      wr(REG_CTRL, 32'h0000_0001);
      fill();
      chk(nrst, 1);
      i_clk_en <= 1'b0;
      stk(1'b1, 1'b0, 15'h0);
      i_clk_en <= 1'b1;
      rdc(REG_STKST, 32'h0);
      $display("test fault reset finished");
      // context saved on entry survives a pointer rewrite
      i_ctx <= 23'h5B_CDEF;
      wr(REG_PTR0, 32'h0000_4321);
      evt(1'b0);
      wr(REG_PTR0, 32'h0000_1111);
      i_ctx <= '0;
      evt(1'b1);
      chk(o_ctx_valid, 1'b1);
      chk(o_ctx, 23'h5B_CDEF);
      chk(o_ptr0, 16'h4321);
      rdc(REG_ISTAT, 32'h0000_0007);
      i_ind_wdata <= 8'h9C;
      $display("test context finished");
      // reads through both pointers over every region
      for (int i = 0; i < 6; i++) begin
         wr(i[0] ? REG_PTR1 : REG_PTR0, {16'h0, tp[i]});
         ex = ta[i][7:0] ^ (tp[i][15] ? 8'hC3 : 8'h5A);
         if (i == 3 || i == 4) ex = 8'h00;
         ind(i[0], 1'b0, tp[i][15] ? 2 : 1, ex);
         if (i < 3 || i == 5) chk(last_a, ta[i]);
      end
      ind(1'b1, 1'b1, 2, 8'h00);
      chk(nwr, 0);
      wr(REG_PTR1, 32'h0000_0123);
      ind(1'b1, 1'b1, 1, 8'h00);
      chk(nwr, 1);
      chk(o_dm_wdata, 8'h9C);
      rdc(REG_ISTAT, 32'h0000_0008);
      $display("test indirect finished");
      end_sim();
   end
endmodule : csip_top_tb
`default_nettype wire
